//--- core/llst_cfg.svh
/*
 * Constants of the link-layer sleep timer control registers: addresses,
 * field positions, reset values and the low-power tick count.
 * Assumes inclusion by bare name from the sequencer and register design files.
 */
`ifndef LLST_CFG_SVH
`define LLST_CFG_SVH
// ----------------------------------------
// Register map
// ----------------------------------------
`define LLST_ADDR_CTRL 32'h5000_3308
`define LLST_ADDR_TIMER 32'h5000_330A
// ----------------------------------------
// Field positions
// ----------------------------------------
`define LLST_CTRL_WAKE_REQ 0
`define LLST_CTRL_IRQ 2
`define LLST_CTRL_PRIO 4
`define LLST_CTRL_SEL_LO 5
`define LLST_CTRL_SEL_HI 6
`define LLST_TIMER_MSB 9
`define LLST_TIME_HI_MSB 18
`define LLST_TIME_HI_LSB 10
// ----------------------------------------
// Reset values and selector codes
// ----------------------------------------
`define LLST_RST_WORD 16'h0000
`define LLST_RST_STORE 10'h000
`define LLST_RST_SEL 2'h0
`define LLST_SEL_STORE 2'h0
`define LLST_SEL_DUR 2'h1
`define LLST_SEL_TIME_LO 2'h2
`define LLST_SEL_TIME_HI 2'h3
// ----------------------------------------
// Timing
// ----------------------------------------
`define LLST_WAKE_LP_TICKS 3'h4
`endif

//--- core/llst_pkg.sv
/*
 * Types shared by the sleep timer control register files.
 * Assumes the configuration header is compiled alongside.
 */
`default_nettype none
package llst_pkg;
   typedef logic [15:0] llst_word_t;
   typedef logic [9:0] llst_fine_t;
   typedef logic [1:0] llst_sel_t;
   typedef enum logic [1:0] {WS_IDLE, WS_COUNT, WS_FIRE} llst_wake_e;
endpackage
`default_nettype wire

//--- core/llst_bus_arb.sv
/*
 * Processor/DMA system bus arbiter steered by the priority bit.
 * Assumes requests synchronous to clock; grants are registered.
 */
`timescale 1ns/100ps
`default_nettype none
module llst_bus_arb (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic prio_dma,
   input wire logic cpu_req,
   input wire logic dma_req,
   output logic cpu_gnt_q,
   output logic dma_gnt_q
);
   logic cpu_gnt_d;
   logic dma_gnt_d;
   assign cpu_gnt_d = cpu_req && !(dma_req && prio_dma);
   assign dma_gnt_d = dma_req && !(cpu_req && !prio_dma);
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cpu_gnt_q <= 1'b0;
         dma_gnt_q <= 1'b0;
      end else if (clk_en) begin
         cpu_gnt_q <= cpu_gnt_d;
         dma_gnt_q <= dma_gnt_d;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   a_cpu_wins_tie:
   assert property (clk_en && cpu_req && dma_req && !prio_dma |=> cpu_gnt_q && !dma_gnt_q)
      else $error("processor lost arbitration at priority 0");
   a_dma_wins_tie:
   assert property (clk_en && cpu_req && dma_req && prio_dma |=> dma_gnt_q && !cpu_gnt_q)
      else $error("DMA lost arbitration at priority 1");
endmodule // llst_bus_arb
`default_nettype wire

//--- core/llst_wake_seq.sv
/*
 * Wake-up interrupt sequencer counting low-power clock ticks.
 * Assumes lp_tick is a one-cycle pulse per low-power clock period.
 */
`timescale 1ns/100ps
`default_nettype none
`include "llst_cfg.svh"
module llst_wake_seq (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic lp_tick,
   input wire logic wake_req,
   input wire logic deep_sleep,
   output logic wake_irq_q
);
   llst_pkg::llst_wake_e state_q;
   llst_pkg::llst_wake_e state_d;
   logic [2:0] cnt_q;
   logic [2:0] cnt_d;
   logic last_tick;
   // Count to four edges: the request lands mid-period, giving 3 to 4 periods
   assign last_tick = lp_tick && (cnt_q == `LLST_WAKE_LP_TICKS - 3'h1);
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      case (state_q)
         llst_pkg::WS_IDLE: begin
            cnt_d = 3'h0;
            if (wake_req && deep_sleep) state_d = llst_pkg::WS_COUNT;
         end
         llst_pkg::WS_COUNT: begin
            if (!deep_sleep) state_d = llst_pkg::WS_IDLE;
            else if (last_tick) state_d = llst_pkg::WS_FIRE;
            else if (lp_tick) cnt_d = cnt_q + 3'h1;
         end
         llst_pkg::WS_FIRE: begin
            // Level held until the core leaves deep sleep
            if (!deep_sleep) state_d = llst_pkg::WS_IDLE;
         end
         default: state_d = llst_pkg::WS_IDLE;
      endcase
   end
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= llst_pkg::WS_IDLE;
         cnt_q <= 3'h0;
         wake_irq_q <= 1'b0;
      end else if (clk_en) begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         wake_irq_q <= (state_d == llst_pkg::WS_FIRE);
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   a_irq_on_fourth:
   assert property ($rose(wake_irq_q) |-> $past(lp_tick) && $past(cnt_q) == 3'h3)
      else $error("wake interrupt not on fourth low-power tick");
   a_irq_holds:
   assert property (wake_irq_q && deep_sleep |=> wake_irq_q)
      else $error("wake interrupt dropped during deep sleep");
endmodule // llst_wake_seq
`default_nettype wire

//--- core/llst_regs.sv
/*
 * General control and sleep timer data registers beside the link-layer
 * sleep logic, with bus arbiter and wake-up sequencer.
 * Assumes a plain register port whose read data follow one cycle later,
 * and link-layer signals synchronous to clock.
 */
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "llst_cfg.svh"
module llst_regs (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic [31:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [15:0] rdata_q,
   input wire logic cpu_req,
   input wire logic dma_req,
   output logic cpu_gnt_q,
   output logic dma_gnt_q,
   output logic bus_priority_select,
   output logic ll_wake_request,
   output logic ll_wake_irq_level,
   input wire logic lp_tick,
   input wire logic ll_deep_sleep,
   input wire logic ll_sleep_entry,
   input wire logic ll_wake_seq,
   input wire logic [9:0] ll_fine_counter,
   output logic ll_fine_load_q,
   output logic [9:0] ll_fine_value_q,
   input wire logic [9:0] deep_sleep_dur,
   input wire logic [18:0] deep_sleep_time_samp,
   input wire logic deep_sleep_stat_monitor
);
   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   function automatic logic hit(input logic [31:0] a, input logic [31:0] base);
      hit = (a == base);
   endfunction

   logic sel_ctrl;
   logic sel_timer;
   logic wr_ctrl;
   logic wr_timer;
   logic rd_any;
   assign sel_ctrl = hit(addr, `LLST_ADDR_CTRL);
   assign sel_timer = hit(addr, `LLST_ADDR_TIMER);
   assign wr_ctrl = wr_stb && sel_ctrl;
   assign wr_timer = wr_stb && sel_timer;
   assign rd_any = rd_stb;

   // ----------------------------------------
   // General control register
   // ----------------------------------------
   logic wake_req_q;
   logic wake_req_d;
   logic prio_q;
   logic prio_d;
   llst_pkg::llst_sel_t rb_sel_q;
   llst_pkg::llst_sel_t rb_sel_d;
   logic wake_irq;

   assign wake_req_d = wr_ctrl ? wdata[`LLST_CTRL_WAKE_REQ] : wake_req_q;
   assign prio_d = wr_ctrl ? wdata[`LLST_CTRL_PRIO] : prio_q;
   assign rb_sel_d = wr_ctrl ? wdata[`LLST_CTRL_SEL_HI:`LLST_CTRL_SEL_LO] : rb_sel_q;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wake_req_q <= 1'b0;
         prio_q <= 1'b0;
         rb_sel_q <= `LLST_RST_SEL;
      end else if (clk_en) begin
         wake_req_q <= wake_req_d;
         prio_q <= prio_d;
         rb_sel_q <= rb_sel_d;
      end
   end

   assign bus_priority_select = prio_q;
   assign ll_wake_request = wake_req_q;
   assign ll_wake_irq_level = wake_irq;

   // Bit 2 mirrors the live interrupt; bits 1, 3 and 15:7 read zero
   llst_pkg::llst_word_t ctrl_word;
   always_comb begin
      ctrl_word = `LLST_RST_WORD;
      ctrl_word[`LLST_CTRL_WAKE_REQ] = wake_req_q;
      ctrl_word[`LLST_CTRL_IRQ] = wake_irq;
      ctrl_word[`LLST_CTRL_PRIO] = prio_q;
      ctrl_word[`LLST_CTRL_SEL_HI:`LLST_CTRL_SEL_LO] = rb_sel_q;
   end

   // ----------------------------------------
   // Fine count store, always-on domain
   // ----------------------------------------
   llst_pkg::llst_fine_t store_q;
   llst_pkg::llst_fine_t store_d;

   // Hardware sample wins over a software write in the same cycle, so the
   // snapshot taken on sleep entry is never lost. Writes ignore the selector.
   assign store_d = ll_sleep_entry ? ll_fine_counter :
                    wr_timer ? wdata[`LLST_TIMER_MSB:0] :
                    store_q;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         store_q <= `LLST_RST_STORE;
      end else if (clk_en) begin
         store_q <= store_d;
      end
   end

   // ----------------------------------------
   // Restore into the link-layer fine counter
   // ----------------------------------------
   // The core only sees the store through this load, taken at wake-up;
   // a write while awake is overwritten by the next sleep entry.
   logic load_d;
   llst_pkg::llst_fine_t value_d;
   assign load_d = ll_wake_seq;
   assign value_d = ll_wake_seq ? store_q : ll_fine_value_q;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ll_fine_load_q <= 1'b0;
         ll_fine_value_q <= `LLST_RST_STORE;
      end else if (clk_en) begin
         ll_fine_load_q <= load_d;
         ll_fine_value_q <= value_d;
      end
   end

   // ----------------------------------------
   // Timer data readback selection
   // ----------------------------------------
   llst_pkg::llst_fine_t timer_rb;
   llst_pkg::llst_word_t timer_word;
   llst_pkg::llst_fine_t time_hi;
   assign time_hi = {deep_sleep_stat_monitor,
                     deep_sleep_time_samp[`LLST_TIME_HI_MSB:`LLST_TIME_HI_LSB]};

   always_comb begin
      case (rb_sel_q)
         `LLST_SEL_STORE: timer_rb = store_q;
         `LLST_SEL_DUR: timer_rb = deep_sleep_dur;
         `LLST_SEL_TIME_LO: timer_rb = deep_sleep_time_samp[`LLST_TIMER_MSB:0];
         `LLST_SEL_TIME_HI: timer_rb = time_hi;
         default: timer_rb = store_q;
      endcase
   end

   // Zero-extend through a generate loop so bits 15:10 stay reserved
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi = gi + 1) begin : g_timer_word
         if (gi <= `LLST_TIMER_MSB) begin : g_data
            assign timer_word[gi] = timer_rb[gi];
         end else begin : g_rsvd
            assign timer_word[gi] = 1'b0;
         end
      end
   endgenerate

   // ----------------------------------------
   // Read data port
   // ----------------------------------------
   // Data stand only in the cycle after the strobe; unmapped reads give zero
   llst_pkg::llst_word_t rd_mux;
   llst_pkg::llst_word_t rdata_d;
   assign rd_mux = sel_ctrl ? ctrl_word :
                   sel_timer ? timer_word :
                   `LLST_RST_WORD;
   assign rdata_d = rd_any ? rd_mux : `LLST_RST_WORD;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rdata_q <= `LLST_RST_WORD;
      end else if (clk_en) begin
         rdata_q <= rdata_d;
      end
   end

   // ----------------------------------------
   // Bus arbiter and wake-up sequencer
   // ----------------------------------------
   llst_bus_arb i_llst_bus_arb (
      .clock(clock),
      .arst_n(arst_n),
      .clk_en(clk_en),
      .prio_dma(prio_q),
      .cpu_req(cpu_req),
      .dma_req(dma_req),
      .cpu_gnt_q(cpu_gnt_q),
      .dma_gnt_q(dma_gnt_q)
   );

   // Holding the request for a low-power period is left to software;
   // the sequencer latches the start so a short pulse still counts.
   llst_wake_seq i_llst_wake_seq (
      .clock(clock),
      .arst_n(arst_n),
      .clk_en(clk_en),
      .lp_tick(lp_tick),
      .wake_req(wake_req_q),
      .deep_sleep(ll_deep_sleep),
      .wake_irq_q(wake_irq)
   );

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   a_ctrl_readback:
   assert property (clk_en && rd_stb && sel_ctrl |=>
                    rdata_q == $past(ctrl_word) && rdata_q[2] == $past(wake_irq))
      else $error("control read does not show interrupt level");

   a_prio_write:
   assert property (clk_en && wr_ctrl |=> bus_priority_select == $past(wdata[4]))
      else $error("priority bit not taken from write");

   a_sleep_sample:
   assert property (clk_en && ll_sleep_entry |=> store_q == $past(ll_fine_counter))
      else $error("fine counter not sampled at sleep entry");

   a_wake_restore:
   assert property (clk_en && ll_wake_seq |=>
                    ll_fine_load_q && ll_fine_value_q == $past(store_q))
      else $error("store not restored at wake-up");

   a_awake_write:
   assert property (clk_en && wr_timer && !ll_deep_sleep && !ll_wake_seq |=>
                    !ll_fine_load_q && $stable(ll_fine_value_q))
      else $error("awake write reached the link-layer core");

   a_write_any_sel:
   assert property (clk_en && wr_timer && !ll_sleep_entry && rb_sel_q != 2'h0 |=>
                    store_q == $past(wdata[9:0]))
      else $error("write with nonzero selector not stored");

   a_sel0_read:
   assert property (clk_en && rd_stb && sel_timer && rb_sel_q == 2'h0 |=>
                    rdata_q == {6'h00, $past(store_q)})
      else $error("selector 0 read not the store");

   a_sel1_read:
   assert property (clk_en && rd_stb && sel_timer && rb_sel_q == 2'h1 |=>
                    rdata_q == {6'h00, $past(deep_sleep_dur)})
      else $error("selector 1 read not the sleep duration");

   a_sel2_read:
   assert property (clk_en && rd_stb && sel_timer && rb_sel_q == 2'h2 |=>
                    rdata_q[9:0] == $past(deep_sleep_time_samp[9:0]))
      else $error("selector 2 read not the low time bits");

   a_sel3_read:
   assert property (clk_en && rd_stb && sel_timer && rb_sel_q == 2'h3 |=>
                    rdata_q[9] == $past(deep_sleep_stat_monitor) &&
                    rdata_q[8:0] == $past(deep_sleep_time_samp[18:10]))
      else $error("selector 3 read not monitor and high time bits");

   a_rsvd_zero:
   assert property (rdata_q[15:7] == 9'h000 && rdata_q[15:10] == 6'h00 ||
                    $past(sel_timer) && rdata_q[15:10] == 6'h00)
      else $error("reserved read bits not zero");

   // ----------------------------------------
   // Hold checks
   // ----------------------------------------
   // State moves only on its own strobe or link event;
   // a stray update would corrupt the fine count unseen.

   a_rdata_idle:
   assert property (clk_en && !rd_stb |=> rdata_q == 16'h0000)
      else $error("read data not zero outside an answer");

   a_unmapped_read:
   assert property (clk_en && rd_stb && !sel_ctrl && !sel_timer |=> rdata_q == 16'h0000)
      else $error("unmapped read not zero");

   a_ctrl_fields:
   assert property (clk_en && wr_ctrl |=>
                    ll_wake_request == $past(wdata[0]) && rb_sel_q == $past(wdata[6:5]))
      else $error("control fields not taken from write");

   a_ctrl_hold:
   assert property (clk_en && !wr_ctrl |=>
                    $stable(prio_q) && $stable(rb_sel_q) && $stable(wake_req_q))
      else $error("control changed without a write");

   a_store_hold:
   assert property (clk_en && !ll_sleep_entry && !wr_timer |=> $stable(store_q))
      else $error("store changed without cause");

   a_sample_wins:
   assert property (clk_en && ll_sleep_entry && wr_timer |=>
                    store_q == $past(ll_fine_counter))
      else $error("write beat the sleep-entry sample");

   a_restore_idle:
   assert property (clk_en && !ll_wake_seq |=>
                    !ll_fine_load_q && $stable(ll_fine_value_q))
      else $error("core value moved outside wake-up");

   a_irq_no_awake:
   assert property (clk_en && !ll_deep_sleep |=> !ll_wake_irq_level)
      else $error("wake interrupt while awake");

   a_timer_rsvd:
   assert property (clk_en && rd_stb && sel_timer |=> rdata_q[15:10] == 6'h00)
      else $error("timer reserved bits not zero");

   a_grant_exclusive:
   assert property (!(cpu_gnt_q && dma_gnt_q))
      else $error("both masters granted");

   a_cpu_alone:
   assert property (clk_en && cpu_req && !dma_req |=> cpu_gnt_q && !dma_gnt_q)
      else $error("lone processor not granted");

   a_dma_alone:
   assert property (clk_en && dma_req && !cpu_req |=> dma_gnt_q && !cpu_gnt_q)
      else $error("lone DMA not granted");

   // Freeze is a whole-block stall, so nothing may move
   a_freeze_hold:
   assert property (!clk_en |=> $stable(rdata_q) && $stable(store_q) && $stable(prio_q))
      else $error("state moved while frozen");

   c_sleep_then_wake:
   cover property (ll_sleep_entry ##[1:50] ll_wake_seq);
   c_wake_irq:
   cover property ($rose(ll_wake_irq_level));
   c_sel3_read:
   cover property (rd_stb && sel_timer && rb_sel_q == 2'h3);
   c_dma_grant:
   cover property (cpu_req && dma_req && prio_q ##1 dma_gnt_q);
   c_frozen_write:
   cover property (!clk_en && wr_stb);
endmodule // llst_regs
`default_nettype wire

//--- testbench/llst_ll_model.sv
/*
 * Behavioural link-layer core beside the sleep timer registers: low-power
 * tick, fine counter, sleep entry and wake sequencing.
 * Assumes bench commands arrive as one-cycle pulses on clock.
 */
`timescale 1ns/100ps
`default_nettype none
module llst_ll_model (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic sleep_cmd,
   input wire logic wake_cmd,
   input wire logic ll_fine_load_q,
   input wire logic [9:0] ll_fine_value_q,
   output logic lp_tick,
   output logic ll_deep_sleep,
   output logic ll_sleep_entry,
   output logic ll_wake_seq,
   output logic [9:0] ll_fine_counter
);
   // ----------------------------------------
   // Low-power clock stand-in, one pulse every 8 cycles
   // ----------------------------------------
   logic [2:0] lp_cnt_q;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         lp_cnt_q <= 3'h0;
         lp_tick <= 1'b0;
         ll_deep_sleep <= 1'b0;
         ll_sleep_entry <= 1'b0;
         ll_wake_seq <= 1'b0;
         ll_fine_counter <= 10'h000;
      end else begin
         lp_cnt_q <= lp_cnt_q + 3'h1;
         lp_tick <= &lp_cnt_q;
         // Counter frozen from the sampling cycle on, so the stored value is exact
         if (ll_fine_load_q) begin
            ll_fine_counter <= ll_fine_value_q;
         end else if (!ll_deep_sleep && !ll_sleep_entry) begin
            ll_fine_counter <= ll_fine_counter + 10'h001;
         end
         ll_sleep_entry <= sleep_cmd && !ll_deep_sleep && !ll_sleep_entry;
         ll_wake_seq <= wake_cmd && ll_deep_sleep;
         if (ll_sleep_entry) begin
            ll_deep_sleep <= 1'b1;
         end else if (ll_wake_seq) begin
            ll_deep_sleep <= 1'b0;
         end
      end
   end
endmodule // llst_ll_model
`default_nettype wire

//--- testbench/tb_top.sv
/*
 * Self-checking bench for the sleep timer control registers.
 * Assumes the link-layer model drives the far side; one scenario freezes clk_en.
 */
`timescale 1ns/100ps
`default_nettype none
`include "llst_cfg.svh"
module tb_top;
   logic clock, arst_n, clk_en, wr_stb, rd_stb, cpu_req, dma_req, sleep_cmd, wake_cmd;
   logic [31:0] addr;
   logic [15:0] wdata, rdata_q, v;
   logic cpu_gnt_q, dma_gnt_q, bus_priority_select, ll_wake_request, ll_wake_irq_level;
   logic lp_tick, ll_deep_sleep, ll_sleep_entry, ll_wake_seq, ll_fine_load_q, mon;
   logic [9:0] ll_fine_counter, ll_fine_value_q, dur;
   logic [18:0] samp;
   int failures, total_checks, n;
   llst_regs i_llst_regs (.clock(clock), .arst_n(arst_n), .clk_en(clk_en), .addr(addr),
      .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_q(rdata_q),
      .cpu_req(cpu_req), .dma_req(dma_req), .cpu_gnt_q(cpu_gnt_q), .dma_gnt_q(dma_gnt_q),
      .bus_priority_select(bus_priority_select), .ll_wake_request(ll_wake_request),
      .ll_wake_irq_level(ll_wake_irq_level), .lp_tick(lp_tick), .ll_deep_sleep(ll_deep_sleep),
      .ll_sleep_entry(ll_sleep_entry), .ll_wake_seq(ll_wake_seq),
      .ll_fine_counter(ll_fine_counter), .ll_fine_load_q(ll_fine_load_q),
      .ll_fine_value_q(ll_fine_value_q), .deep_sleep_dur(dur),
      .deep_sleep_time_samp(samp), .deep_sleep_stat_monitor(mon));
   llst_ll_model i_llst_ll_model (.clock(clock), .arst_n(arst_n), .sleep_cmd(sleep_cmd),
      .wake_cmd(wake_cmd), .ll_fine_load_q(ll_fine_load_q), .ll_fine_value_q(ll_fine_value_q),
      .lp_tick(lp_tick), .ll_deep_sleep(ll_deep_sleep), .ll_sleep_entry(ll_sleep_entry),
      .ll_wake_seq(ll_wake_seq), .ll_fine_counter(ll_fine_counter));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   // Each access opens on a fresh edge, so back-to-back calls leave an idle cycle
   task automatic wr(input logic [31:0] a, input logic [15:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clock);
      wr_stb <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a, output logic [15:0] d);
      @(posedge clock);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clock);
      rd_stb <= 1'b0;
      #1 d = rdata_q;
   endtask
   task automatic pulse_sleep(input bit wake);
      @(posedge clock);
      if (wake) wake_cmd <= 1'b1;
      else sleep_cmd <= 1'b1;
      @(posedge clock);
      wake_cmd <= 1'b0;
      sleep_cmd <= 1'b0;
      repeat (3) @(posedge clock);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      rd(`LLST_ADDR_CTRL, v);
      chk(v, 16'h0000, "ctrl reset");
      rd(`LLST_ADDR_TIMER, v);
      chk(v, 16'h0000, "timer reset");
      wr(`LLST_ADDR_CTRL, 16'hFFFF);
      rd(`LLST_ADDR_CTRL, v);
      chk(v, 16'h0071, "ctrl reserved and read-only bits");
      chk({14'h0, bus_priority_select, ll_wake_request}, 16'h0003, "ctrl outputs");
      rd(32'h5000_330C, v);
      chk(v, 16'h0000, "unmapped read");
      repeat (40) @(posedge clock);
      chk({15'h0, ll_wake_irq_level}, 16'h0000, "awake request ignored");
      wr(`LLST_ADDR_CTRL, 16'h0000);
      $display("test reset done");
   endtask
   task automatic t_arb();
      cpu_req <= 1'b1;
      dma_req <= 1'b1;
      repeat (3) @(posedge clock);
      chk({14'h0, cpu_gnt_q, dma_gnt_q}, 16'h0002, "tie to processor");
      wr(`LLST_ADDR_CTRL, 16'h0010);
      repeat (2) @(posedge clock);
      chk({14'h0, cpu_gnt_q, dma_gnt_q}, 16'h0001, "tie to dma");
      dma_req <= 1'b0;
      repeat (2) @(posedge clock);
      chk({14'h0, cpu_gnt_q, dma_gnt_q}, 16'h0002, "lone processor");
      cpu_req <= 1'b0;
      wr(`LLST_ADDR_CTRL, 16'h0000);
      $display("test arbiter done");
   endtask
   task automatic t_sleep();
      pulse_sleep(1'b0);
      rd(`LLST_ADDR_TIMER, v);
      chk(v, {6'h0, ll_fine_counter}, "sampled fine count");
      wr(`LLST_ADDR_TIMER, 16'hFEA5);
      rd(`LLST_ADDR_TIMER, v);
      chk(v, 16'h02A5, "software store while asleep");
      @(posedge clock);
      wake_cmd <= 1'b1;
      @(posedge clock);
      wake_cmd <= 1'b0;
      n = 0;
      while (ll_fine_load_q !== 1'b1 && n < 5) begin
         @(posedge clock);
         #1;
         n++;
      end
      chk({15'h0, ll_fine_load_q}, 16'h0001, "restore pulse");
      chk({6'h0, ll_fine_value_q}, 16'h02A5, "restored value");
      if (n >= 5) summarize();
      $display("test sleep done");
   endtask
   task automatic t_awake();
      wr(`LLST_ADDR_TIMER, 16'h0155);
      n = 0;
      repeat (6) begin
         @(posedge clock);
         if (ll_fine_load_q !== 1'b0) n++;
      end
      chk(n[15:0], 16'h0000, "no load while awake");
      chk({6'h0, ll_fine_value_q}, 16'h02A5, "core value untouched");
      $display("test awake write done");
   endtask
   task automatic t_sel();
      logic [15:0] e [4];
      e[1] = {6'h0, dur};
      e[2] = {6'h0, samp[9:0]};
      e[3] = {6'h0, mon, samp[18:10]};
      for (int s = 1; s < 4; s++) begin
         wr(`LLST_ADDR_CTRL, {9'h0, s[1:0], 5'h00});
         rd(`LLST_ADDR_TIMER, v);
         chk(v, e[s], "selector readback");
      end
      wr(`LLST_ADDR_TIMER, 16'h00F0);
      wr(`LLST_ADDR_CTRL, 16'h0000);
      rd(`LLST_ADDR_TIMER, v);
      chk(v, 16'h00F0, "write under nonzero selector");
      $display("test selector done");
   endtask
   task automatic t_wake();
      pulse_sleep(1'b0);
      wr(`LLST_ADDR_CTRL, 16'h0001);
      n = 0;
      while (ll_wake_irq_level !== 1'b1 && n < 60) begin
         @(posedge clock);
         n++;
      end
      chk({15'h0, n >= 22 && n <= 34}, 16'h0001, "wake delay in low-power periods");
      rd(`LLST_ADDR_CTRL, v);
      chk(v, 16'h0005, "irq level in control");
      // Request held well past one low-power period before clearing
      wr(`LLST_ADDR_CTRL, 16'h0000);
      pulse_sleep(1'b1);
      rd(`LLST_ADDR_CTRL, v);
      chk(v, 16'h0000, "irq cleared after wake");
      $display("test wake irq done");
   endtask
   task automatic t_freeze();
      clk_en <= 1'b0;
      wr(`LLST_ADDR_CTRL, 16'h0010);
      repeat (2) @(posedge clock);
      chk({15'h0, bus_priority_select}, 16'h0000, "write lost while frozen");
      clk_en <= 1'b1;
      wr(`LLST_ADDR_CTRL, 16'h0070);
      @(posedge clock);
      chk({15'h0, bus_priority_select}, 16'h0001, "write taken when enabled");
      arst_n <= 1'b0;
      repeat (2) @(posedge clock);
      arst_n <= 1'b1;
      rd(`LLST_ADDR_CTRL, v);
      chk(v, 16'h0000, "control cleared by reset");
      rd(`LLST_ADDR_TIMER, v);
      chk(v, 16'h0000, "store cleared by reset");
      $display("test freeze and reset done");
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      failures = 0;
      total_checks = 0;
      arst_n = 1'b0;
      {wr_stb, rd_stb, cpu_req, dma_req, sleep_cmd, wake_cmd} = 6'h00;
      addr = 32'h0000_0000;
      wdata = 16'h0000;
      clk_en = 1'b1;
      dur = 10'h3C3;
      samp = 19'h4_B2D1;
      mon = 1'b1;
      repeat (12) @(posedge clock);
      arst_n <= 1'b1;
      t_reset();
      t_arb();
      t_sleep();
      t_awake();
      t_sel();
      t_wake();
      t_freeze();
      summarize();
   end
endmodule // tb_top
`default_nettype wire
